/* bench/spi_gate_asserts.sv */
`timescale 1ns/1ps
`include "spi_gate_consts.svh"
module spi_gate_asserts (
    input wire logic mclk,
    input wire logic srst,
    input wire spi_gate_pkg::spi_pins_t spi_in,
    input wire spi_gate_pkg::supply_t supply,
    input wire spi_gate_pkg::frame_src_t frame_src,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_n,
    input wire logic miso_n_oe,
    input wire logic power_ok,
    input wire logic sleeping
);
    import spi_gate_pkg::*;
    // ----
    // Checks
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence sel_start;
        $fell(spi_in.cs_n) && power_ok && !sleeping;
    endsequence
    chk_oe_pair: assert property (miso_oe == miso_n_oe) else $error("oe differ");
    chk_out_compl: assert property (miso_oe |-> miso_n != miso) else $error("no compl");
    chk_loss_low: assert property (miso_oe && !power_ok && !$past(power_ok) |-> !miso)
        else $error("loss out");
    chk_sleep_low: assert property (miso_oe && sleeping && $past(sleeping) |-> !miso)
        else $error("sleep out");
    chk_por_level: assert property (!srst |=> power_ok == ($past(supply.sensor_mv) >=
        `SENSOR_MIN_MV && $past(supply.logic_mv) >= `LOGIC_MIN_MV)) else $error("por");
    chk_sleep_level: assert property (!srst |=> sleeping ==
        ($past(supply.sensor_mv) < `SENSOR_MIN_MV)) else $error("sleep");
    chk_cs_release: assert property (spi_in.cs_n [*5] |-> !miso_oe) else $error("oe");
    chk_first_msb: assert property (sel_start |-> ##3 miso_oe &&
        miso == frame_src.inputs[7]) else $error("msb");
endmodule // spi_gate_asserts
bind spi_output_power_loss_gating spi_gate_asserts spi_gate_asserts_i (.mclk, .srst, .spi_in,
    .supply, .frame_src, .miso, .miso_oe, .miso_n, .miso_n_oe, .power_ok,
    .sleeping);

/* bench/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
    input wire logic mclk,
    input wire logic miso,
    output spi_gate_pkg::spi_pins_t pins
);
    import spi_gate_pkg::*;
    initial pins = 3'h2;
    // ----
    // Frame, clock idles low
    // ----
    task automatic xfer(input int n, output logic [15:0] d);
        d = 16'h0000;
        @(posedge mclk) pins.cs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < n; i++)
        begin
            pins.sck <= 1'b1;
            pins.mosi <= ~pins.mosi;
            repeat (3) @(posedge mclk);
            d = {d[14:0], miso};
            @(posedge mclk) pins.sck <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        pins.cs_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule // spi_master_model

/* bench/tb.sv */
`timescale 1ns/1ps
`include "spi_gate_consts.svh"
module tb;
    import spi_gate_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    spi_pins_t pins;
    supply_t supply = {`SENSOR_MIN_MV, `LOGIC_MIN_MV};
    frame_src_t src = {8'hB4, 2'h3};
    logic fls = 1'b0;
    logic miso, miso_oe, miso_n, miso_n_oe, power_ok, sleeping, line;
    logic [15:0] d;
    int n_mismatch = 0;
    int checks = 0;
    always #25 mclk = ~mclk;
    assign line = miso_oe ? miso : ~miso;
    spi_output_power_loss_gating spi_output_power_loss_gating_i (.mclk, .srst, .spi_in(pins),
        .supply, .frame_src(src), .frame_length_select(fls), .miso, .miso_oe, .miso_n,
        .miso_n_oe, .power_ok, .sleeping);
    spi_master_model spi_master_model_i (.mclk, .miso(line), .pins);
    // ----
    // Scenarios
    // ----
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_long();
        spi_master_model_i.xfer(16, d);
        check("long", d & 16'hFFC3, 16'hB4C1);
        check("idle", {14'h0000, miso_oe, miso_n_oe}, 16'h0000);
    endtask
    task automatic t_short();
        fls <= 1'b1;
        src.undervoltage_alarm_n <= 1'b0;
        repeat (4) @(posedge mclk);
        spi_master_model_i.xfer(16, d);
        check("short", d, 16'hB400);
        fls <= 1'b0;
        src.undervoltage_alarm_n <= 1'b1;
    endtask
    task automatic t_supply(input logic [15:0] s, input logic [15:0] l, input logic [15:0] st);
        supply <= {s, l};
        repeat (4) @(posedge mclk);
        check("state", {power_ok, sleeping}, st);
        spi_master_model_i.xfer(16, d);
        check("loss", d, 16'h0000);
        check("idle", {14'h0000, miso_oe, miso_n_oe}, 16'h0000);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_long();
        t_short();
        t_supply(`SENSOR_MIN_MV - 16'h0001, `LOGIC_MIN_MV, 16'h0001);
        t_supply(`SENSOR_MIN_MV, `LOGIC_MIN_MV - 16'h0001, 16'h0000);
        supply <= {`SENSOR_MIN_MV, `LOGIC_MIN_MV};
        repeat (4) @(posedge mclk);
        t_long();
        give_verdict();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule // tb

/* rtl/spi_gate_consts.svh */
`ifndef SPI_GATE_CONSTS_SVH
`define SPI_GATE_CONSTS_SVH

// Supply thresholds in millivolts
`define SENSOR_MIN_MV 16'd9000
`define LOGIC_MIN_MV 16'd3250

// Frame layout
`define FRAME_LONG_BITS 5'd16
`define FRAME_SHORT_BITS 5'd8
`define STOP_HIGH_POS 0
`define STOP_LOW_POS 1
`define UNDERVOLTAGE_ALARM_POS 7
`define OTA_POS 6
`define PARITY_LSB 2

`endif

/* rtl/spi_gate_pkg.sv */
package spi_gate_pkg;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic mosi;
    } spi_pins_t;

    typedef struct packed {
        logic [15:0] sensor_mv;
        logic [15:0] logic_mv;
    } supply_t;

    typedef struct packed {
        logic [7:0] inputs;
        logic undervoltage_alarm_n;
        logic overtemp_alarm_n;
    } frame_src_t;

endpackage

/* rtl/spi_output_power_loss_gating.sv */
`timescale 1ns/1ps
`include "spi_gate_consts.svh"

// How it works
// - Without sensor supply the block sleeps and its data output stays low in any transfer.
// - The last bit of a normal frame is a stop bit that is always high.
// - Power-loss reset is low when sensor supply is under 9 V or logic supply under 3.25 V.
// - With chip select high both data outputs are released, regardless of power-loss reset.
// - Powered and selected, the output drives frame data and the companion its complement.
// - In power loss and selected, the output is low and the companion high.
// - Frame bits leave most significant first, so the stop bit goes last.
// - Frame select low sends 16 bits, high sends the 8 input bits followed by 8 zero bits.
// - Long frames carry a low stop bit and a high stop bit with alarm and parity bits.
module spi_output_power_loss_gating (
    input wire logic mclk,
    input wire logic srst,
    input wire spi_gate_pkg::spi_pins_t spi_in,
    input wire spi_gate_pkg::supply_t supply,
    input wire spi_gate_pkg::frame_src_t frame_src,
    input wire logic frame_length_select,
    output logic miso,
    output logic miso_oe,
    output logic miso_n,
    output logic miso_n_oe,
    output logic power_ok,
    output logic sleeping
);
    import spi_gate_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] pins_s;
    logic [9:0] src_s;

    sync2 #(.W(3)) u_sync_pins (
        .mclk(mclk),
        .srst(srst),
        .d({spi_in.sck, ~spi_in.cs_n, frame_length_select}),
        .q(pins_s)
    );

    sync2 #(.W(10)) u_sync_src (
        .mclk(mclk),
        .srst(srst),
        .d({frame_src.inputs, frame_src.undervoltage_alarm_n, frame_src.overtemp_alarm_n}),
        .q(src_s)
    );

    logic sck_s;
    logic cs_n_s;
    logic short_s;
    assign sck_s = pins_s[2];
    assign cs_n_s = ~pins_s[1];
    assign short_s = pins_s[0];

    // ----------------------------------------
    // Supply monitor
    // ----------------------------------------
    logic por_n_r;
    logic sleep_r;

    function automatic logic sensor_ok(input logic [15:0] mv);
        return mv >= `SENSOR_MIN_MV;
    endfunction

    function automatic logic logic_ok(input logic [15:0] mv);
        return mv >= `LOGIC_MIN_MV;
    endfunction

    always_ff @(posedge mclk)
    begin
        if (srst)
            por_n_r <= 1'b0;
        else
            por_n_r <= sensor_ok(supply.sensor_mv) && logic_ok(supply.logic_mv);
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            sleep_r <= 1'b1;
        else
            sleep_r <= !sensor_ok(supply.sensor_mv);
    end

    assign power_ok = por_n_r;
    assign sleeping = sleep_r;

    // ----------------------------------------
    // Frame build
    // ----------------------------------------
    function automatic logic xnor2(input logic a, input logic b);
        return ~(a ^ b);
    endfunction

    function automatic logic pair_parity(input logic a, input logic b, input logic c,
                                         input logic d);
        return xnor2(a, b) ^ xnor2(c, d);
    endfunction

    function automatic logic [15:0] build_frame(input logic [7:0] in_bits,
                                                 input logic uv_n, input logic ota_n);
        logic [15:0] f;
        f = 16'h0000;
        f[15:8] = in_bits;
        f[`UNDERVOLTAGE_ALARM_POS] = uv_n;
        f[`OTA_POS] = ota_n;
        f[`PARITY_LSB + 3] = pair_parity(in_bits[0], in_bits[1], in_bits[2], in_bits[3]);
        f[`PARITY_LSB + 2] = pair_parity(in_bits[4], in_bits[5], in_bits[6], in_bits[7]);
        f[`PARITY_LSB + 1] = pair_parity(in_bits[0], in_bits[2], in_bits[4], in_bits[6]);
        f[`PARITY_LSB] = pair_parity(in_bits[1], in_bits[3], in_bits[5], in_bits[7]);
        f[`STOP_LOW_POS] = 1'b0;
        f[`STOP_HIGH_POS] = 1'b1;
        return f;
    endfunction

    // ----------------------------------------
    // Link edges
    // ----------------------------------------
    logic sck_d_r;
    logic cs_n_d_r;
    logic sck_fall;
    logic cs_fall;

    always_ff @(posedge mclk)
    begin
        if (srst)
            sck_d_r <= 1'b0;
        else
            sck_d_r <= sck_s;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            cs_n_d_r <= 1'b1;
        else
            cs_n_d_r <= cs_n_s;
    end

    assign sck_fall = sck_d_r & ~sck_s;
    assign cs_fall = cs_n_d_r & ~cs_n_s;

    // ----------------------------------------
    // Frame capture
    // ----------------------------------------
    logic [15:0] frame_full;
    logic [15:0] frame_load;

    assign frame_full = build_frame(src_s[9:2], src_s[1], src_s[0]);

    always_comb
    begin
        if (short_s)
            frame_load = {frame_full[15:8], 8'h00};
        else
            frame_load = frame_full;
    end

    // ----------------------------------------
    // Shift register
    // ----------------------------------------
    logic [15:0] shift_r;

    always_ff @(posedge mclk)
    begin
        if (srst)
            shift_r <= 16'h0000;
        else if (cs_fall)
            shift_r <= frame_load;
        else if (!cs_n_s && sck_fall)
            shift_r <= {shift_r[14:0], 1'b0};
    end

    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    logic lost;
    logic data_bit;

    assign lost = !por_n_r || sleep_r;
    assign data_bit = cs_fall ? frame_load[15] : shift_r[15];

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            miso_oe <= 1'b0;
            miso_n_oe <= 1'b0;
        end
        else
        begin
            miso_oe <= ~cs_n_s;
            miso_n_oe <= ~cs_n_s;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            miso <= 1'b0;
            miso_n <= 1'b1;
        end
        else if (lost)
        begin
            miso <= 1'b0;
            miso_n <= 1'b1;
        end
        else
        begin
            miso <= data_bit;
            miso_n <= ~data_bit;
        end
    end

endmodule // spi_output_power_loss_gating

/* rtl/sync2.sv */
`timescale 1ns/1ps

module sync2 #(
    parameter int W = 1
)(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule // sync2
